// file: rtl/cgc_pkg.sv
// constants for the clock generator configuration registers
package cgc_pkg;
    // byte indices of the register bank
    localparam logic [7:0] IDX_SPREAD = 8'h01;
    localparam logic [7:0] IDX_EDGE = 8'h02;
    localparam logic [7:0] IDX_REF = 8'h03;
    localparam logic [7:0] IDX_RSVD = 8'h04;
    localparam logic [7:0] IDX_IDENT = 8'h05;
    localparam logic [7:0] IDX_PART = 8'h06;
    localparam logic [7:0] IDX_LENGTH = 8'h07;
    // field positions
    localparam int OVR_BIT = 5;
    localparam int SEL_HI = 4;
    localparam int SEL_LO = 3;
    localparam int SWING_HI = 1;
    localparam int EDGE_HI = 2;
    localparam int EDGE_LO = 1;
    localparam int REF_EDGE_HI = 7;
    localparam int REF_EDGE_LO = 6;
    localparam int KEEP_BIT = 5;
    localparam int REF_EN_BIT = 4;
    localparam int LEN_HI = 4;
    // spread codes
    localparam logic [1:0] SPREAD_OFF = 2'h0;
    localparam logic [1:0] SPREAD_RSVD = 2'h2;
    // reset values
    localparam logic RST_OVR = 1'h0;
    localparam logic [1:0] RST_SEL = 2'h0;
    localparam logic [1:0] RST_SWING = 2'h2;
    localparam logic [1:0] RST_EDGE = 2'h3;
    localparam logic [1:0] RST_REF_EDGE = 2'h1;
    localparam logic RST_KEEP = 1'h0;
    localparam logic RST_REF_EN = 1'h1;
    localparam logic [4:0] RST_LENGTH = 5'h08;
    // read values of fixed bytes and reserved bits
    localparam logic [7:0] RSVD_BYTE = 8'hFF;
    localparam logic [4:0] EDGE_RSVD_HI = 5'h1F;
    localparam logic [3:0] REF_RSVD_LO = 4'hF;
    localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
    // serial frame
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage

// file: rtl/cgc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module cgc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } cgc_sync_st_t;

    cgc_sync_st_t q;
    cgc_sync_st_t d;

    always_comb
    begin
        d.meta = i_async;
        d.stable = q.meta;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_sync = q.stable;
endmodule
`default_nettype wire

// file: rtl/cgc_regs.sv
// serial-bus configuration register bank of the clock generator
// How it works
// - latched three-level spread strap reads at byte 1 bits 7:6 as 00/01/11.
// - byte 1 bit 5 picks strap (0) or software select (1); resets 0.
// - software select 00 off, 01 -0.25%, 10 reserved, 11 -0.5%; resets 0.
// - select bits stored always but only act when override bit is 1.
// - byte 1 bits 1:0 set swing 0.6/0.7/0.8/0.9V; resets to 10.
// - byte 2 bits 2 and 1 edge rate per output, 1 is faster; reset 1.
// - byte 3 bit 5 keeps reference in power-down; bit 4 enables it.
// - byte 4 is reserved and always reads all ones.
// - byte 7 bits 4:0 hold the block-read byte count, default 8.
// - block read sends the count first, then bytes from the set index.
`timescale 1ns/1ps
`default_nettype none
module cgc_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h50,
    parameter logic [3:0] REV_CODE = 4'h5,   // arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'hA, // arbitrary value
    parameter logic [1:0] PART_CLASS = 2'h3, // arbitrary value
    parameter logic [5:0] PART_CODE = 6'h2A  // arbitrary value
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RSTN,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic [1:0] I_SPREAD_STRAP,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    output logic [1:0] O_SPREAD_SEL,
    output logic [1:0] O_SWING_SEL,
    output logic [1:0] O_EDGE_FAST,
    output logic [1:0] O_REF_EDGE,
    output logic O_REF_KEEP_PD,
    output logic O_REF_EN
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WCNT, ST_WDATA, ST_RDATA, ST_IGNORE
    } cgc_state_t;

    typedef struct packed {
        cgc_state_t state;
        logic scl_p;
        logic sda_p;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] idx;
        logic [7:0] left;
        logic first;
        logic nack;
        logic sda_oe;
        logic sda_out;
        logic [1:0] strap_wait;
        logic strap_ok;
        logic [1:0] strap;
        logic sw_ovr;
        logic [1:0] sw_sel;
        logic [1:0] swing;
        logic [1:0] edge_fast;
        logic [1:0] ref_edge;
        logic ref_keep;
        logic ref_en;
        logic [4:0] length;
        logic [1:0] spread;
    } cgc_st_t;

    cgc_st_t q;
    cgc_st_t d;
    logic [3:0] sync_out;
    logic scl_s;
    logic sda_s;
    logic [1:0] strap_s;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    logic receiving;
    logic wr_en;
    logic [7:0] wr_data;
    logic load;
    logic [7:0] tx_byte;
    logic [7:0] rd_now;

    cgc_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_clk(I_SYS_CLK),
        .i_rstn(I_RSTN),
        .i_async({I_SPREAD_STRAP, I_SDA, I_SCL}),
        .o_sync(sync_out)
    );

    assign scl_s = sync_out[0];
    assign sda_s = sync_out[1];
    assign strap_s = sync_out[3:2];

    function automatic logic [7:0] rd_byte(input cgc_st_t s);
        case (s.idx)
            cgc_pkg::IDX_SPREAD: rd_byte = {s.strap, s.sw_ovr, s.sw_sel,
                                            1'b1, s.swing};
            cgc_pkg::IDX_EDGE: rd_byte = {cgc_pkg::EDGE_RSVD_HI,
                                          s.edge_fast, 1'b1};
            cgc_pkg::IDX_REF: rd_byte = {s.ref_edge, s.ref_keep, s.ref_en,
                                         cgc_pkg::REF_RSVD_LO};
            cgc_pkg::IDX_RSVD: rd_byte = cgc_pkg::RSVD_BYTE;
            cgc_pkg::IDX_IDENT: rd_byte = {REV_CODE, MAKER_CODE};
            cgc_pkg::IDX_PART: rd_byte = {PART_CLASS, PART_CODE};
            cgc_pkg::IDX_LENGTH: rd_byte = {3'h0, s.length};
            default: rd_byte = cgc_pkg::UNMAPPED_BYTE;
        endcase
    endfunction

    assign start_ev = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign stop_ev = scl_s & q.scl_p & ~q.sda_p & sda_s;
    assign scl_rise = scl_s & ~q.scl_p;
    assign scl_fall = ~scl_s & q.scl_p;
    assign receiving = (q.state == ST_ADDR) || (q.state == ST_CMD) ||
                       (q.state == ST_WCNT) || (q.state == ST_WDATA);
    assign rd_now = rd_byte(q);
    assign wr_data = q.shreg;
    assign wr_en = scl_fall && !start_ev && !stop_ev &&
                   q.state == ST_WDATA && q.bitcnt == cgc_pkg::BIT_ACK &&
                   q.left != 8'h00;
    assign load = scl_fall && q.state == ST_RDATA &&
                  q.bitcnt == cgc_pkg::BIT_END && !q.nack;
    assign tx_byte = q.first ? {3'h0, q.length} : rd_now;

    always_comb
    begin
        d = q;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        // strap is caught once, after the synchroniser has filled
        if (!q.strap_ok)
        begin
            if (q.strap_wait == cgc_pkg::STRAP_SETTLE)
            begin
                d.strap = strap_s;
                d.strap_ok = 1'b1;
            end
            else
            begin
                d.strap_wait = q.strap_wait + 2'h1;
            end
        end
        // reserved software code falls back to spread off
        if (!q.sw_ovr)
            d.spread = q.strap;
        else if (q.sw_sel == cgc_pkg::SPREAD_RSVD)
            d.spread = cgc_pkg::SPREAD_OFF;
        else
            d.spread = q.sw_sel;
        if (start_ev)
        begin
            d.state = ST_ADDR;
            d.bitcnt = 4'h0;
            d.sda_oe = 1'b0;
            d.nack = 1'b0;
        end
        else if (stop_ev)
        begin
            d.state = ST_IDLE;
            d.sda_oe = 1'b0;
        end
        else if (scl_rise && q.state != ST_IDLE && q.state != ST_IGNORE)
        begin
            if (receiving && q.bitcnt < cgc_pkg::BIT_ACK)
                d.shreg = {q.shreg[6:0], sda_s};
            if (q.state == ST_RDATA && q.bitcnt == cgc_pkg::BIT_ACK)
                d.nack = sda_s;
            d.bitcnt = q.bitcnt + 4'h1;
        end
        else if (scl_fall && q.state != ST_IDLE && q.state != ST_IGNORE)
        begin
            if (q.bitcnt == cgc_pkg::BIT_ACK)
            begin
                d.sda_oe = 1'b0;
                case (q.state)
                    ST_ADDR:
                    begin
                        if (q.shreg[7:1] == DEV_ADDR)
                        begin
                            d.sda_oe = 1'b1;
                            d.state = q.shreg[0] ? ST_RDATA : ST_CMD;
                            d.first = 1'b1;
                        end
                        else
                        begin
                            d.state = ST_IGNORE;
                        end
                    end
                    ST_CMD:
                    begin
                        d.idx = q.shreg;
                        d.sda_oe = 1'b1;
                        d.state = ST_WCNT;
                    end
                    ST_WCNT:
                    begin
                        d.left = q.shreg;
                        d.sda_oe = 1'b1;
                        d.state = ST_WDATA;
                    end
                    ST_WDATA:
                    begin
                        // bytes past the announced count are refused
                        if (wr_en)
                        begin
                            d.sda_oe = 1'b1;
                            d.idx = q.idx + 8'h01;
                            d.left = q.left - 8'h01;
                        end
                    end
                    default:
                    begin
                        d.sda_oe = 1'b0;
                    end
                endcase
            end
            else if (q.bitcnt == cgc_pkg::BIT_END)
            begin
                d.bitcnt = 4'h0;
                d.sda_oe = 1'b0;
                if (q.state == ST_RDATA && q.nack)
                    d.state = ST_IGNORE;
                else if (load)
                begin
                    d.sda_oe = ~tx_byte[7];
                    d.shreg = {tx_byte[6:0], 1'b0};
                    d.first = 1'b0;
                    if (!q.first)
                        d.idx = q.idx + 8'h01;
                end
            end
            else if (q.state == ST_RDATA)
            begin
                d.sda_oe = ~q.shreg[7];
                d.shreg = {q.shreg[6:0], 1'b0};
            end
        end
        if (wr_en)
        begin
            case (q.idx)
                cgc_pkg::IDX_SPREAD:
                begin
                    d.sw_ovr = wr_data[cgc_pkg::OVR_BIT];
                    d.sw_sel = wr_data[cgc_pkg::SEL_HI:cgc_pkg::SEL_LO];
                    d.swing = wr_data[cgc_pkg::SWING_HI:0];
                end
                cgc_pkg::IDX_EDGE:
                    d.edge_fast =
                        wr_data[cgc_pkg::EDGE_HI:cgc_pkg::EDGE_LO];
                cgc_pkg::IDX_REF:
                begin
                    d.ref_edge =
                        wr_data[cgc_pkg::REF_EDGE_HI:cgc_pkg::REF_EDGE_LO];
                    d.ref_keep = wr_data[cgc_pkg::KEEP_BIT];
                    d.ref_en = wr_data[cgc_pkg::REF_EN_BIT];
                end
                cgc_pkg::IDX_LENGTH:
                    d.length = wr_data[cgc_pkg::LEN_HI:0];
                default:
                    d.length = q.length;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            q <= '{state: ST_IDLE, scl_p: 1'b1, sda_p: 1'b1, bitcnt: 4'h0,
                   shreg: 8'h00, idx: 8'h00, left: 8'h00, first: 1'b0,
                   nack: 1'b0, sda_oe: 1'b0, sda_out: 1'b0,
                   strap_wait: 2'h0, strap_ok: 1'b0, strap: 2'h0,
                   sw_ovr: cgc_pkg::RST_OVR, sw_sel: cgc_pkg::RST_SEL,
                   swing: cgc_pkg::RST_SWING, edge_fast: cgc_pkg::RST_EDGE,
                   ref_edge: cgc_pkg::RST_REF_EDGE,
                   ref_keep: cgc_pkg::RST_KEEP, ref_en: cgc_pkg::RST_REF_EN,
                   length: cgc_pkg::RST_LENGTH,
                   spread: cgc_pkg::SPREAD_OFF};
        end
        else
        begin
            q <= d;
        end
    end

    assign O_SDA_OUT = q.sda_out;
    assign O_SDA_OE = q.sda_oe;
    assign O_SPREAD_SEL = q.spread;
    assign O_SWING_SEL = q.swing;
    assign O_EDGE_FAST = q.edge_fast;
    assign O_REF_EDGE = q.ref_edge;
    assign O_REF_KEEP_PD = q.ref_keep;
    assign O_REF_EN = q.ref_en;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RSTN);

    a_strap_latch_once: assert property (q.strap_ok |=> $stable(q.strap)
        && (rd_now[7:6] == q.strap || q.idx != cgc_pkg::IDX_SPREAD))
        else $error("strap readback changed after latch");
    a_spread_from_strap: assert property (!q.sw_ovr |=>
        O_SPREAD_SEL == $past(q.strap))
        else $error("spread does not follow strap");
    a_spread_software: assert property (q.sw_ovr &&
        q.sw_sel != cgc_pkg::SPREAD_RSVD |=> O_SPREAD_SEL == $past(q.sw_sel))
        else $error("software spread select not applied");
    a_select_stored: assert property (wr_en && q.idx == cgc_pkg::IDX_SPREAD
        |=> q.sw_sel == $past(wr_data[4:3]))
        else $error("software select bits not stored");
    a_swing_write: assert property (wr_en && q.idx == cgc_pkg::IDX_SPREAD
        |=> O_SWING_SEL == $past(wr_data[1:0]))
        else $error("swing field not written");
    a_edge_write: assert property (wr_en && q.idx == cgc_pkg::IDX_EDGE
        |=> O_EDGE_FAST == $past(wr_data[2:1]))
        else $error("edge rate field not written");
    a_ref_write: assert property (wr_en && q.idx == cgc_pkg::IDX_REF
        |=> O_REF_KEEP_PD == $past(wr_data[5]) &&
        O_REF_EN == $past(wr_data[4]))
        else $error("reference control not written");
    a_rsvd_ones: assert property (q.idx == cgc_pkg::IDX_RSVD |->
        rd_now == 8'hFF)
        else $error("reserved byte not all ones");
    a_count_write: assert property (wr_en && q.idx == cgc_pkg::IDX_LENGTH
        |=> q.length == $past(wr_data[4:0]) ##1 $stable(q.length)
        || $past(wr_en))
        else $error("byte count not written");
    a_count_first: assert property (load && q.first |=> O_SDA_OE &&
        q.shreg == {2'h0, $past(q.length), 1'b0} && !q.first)
        else $error("block read did not start with count");
    a_ident_fixed: assert property (q.idx == cgc_pkg::IDX_PART |->
        rd_now == {PART_CLASS, PART_CODE})
        else $error("identification byte not fixed");

    c_block_write: cover property (wr_en ##[1:1000] wr_en);
    c_block_read: cover property (load && q.first ##[1:1000] load);
    c_host_nack: cover property (q.state == ST_RDATA ##1
        q.state == ST_IGNORE);
    c_override_on: cover property ($rose(q.sw_ovr));
endmodule
`default_nettype wire

// file: bench/cgc_host_model.sv
// serial bus host model issuing indexed block transfers
`timescale 1ns/1ps
`default_nettype none
module cgc_host_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda,
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte
);
    // six clocks a quarter bit keeps each edge clear of the sync flops
    localparam int QTR = 6;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_rx_valid = 1'b0;
        o_rx_byte = 8'h00;
    end
    task automatic wait_q();
        repeat (QTR) @(negedge i_clk);
    endtask
    // data changes only a quarter bit after the clock fell
    task automatic bit_io(input logic v, output logic s);
        o_sda = v;
        wait_q();
        o_scl = 1'b1;
        wait_q();
        s = i_sda;
        wait_q();
        o_scl = 1'b0;
        wait_q();
    endtask
    task automatic start();
        o_sda = 1'b1;
        wait_q();
        o_scl = 1'b1;
        wait_q();
        o_sda = 1'b0;
        wait_q();
        o_scl = 1'b0;
        wait_q();
    endtask
    task automatic stop();
        o_sda = 1'b0;
        wait_q();
        o_scl = 1'b1;
        wait_q();
        o_sda = 1'b1;
        wait_q();
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], ack);
        bit_io(1'b1, ack);
    endtask
    // a not-acknowledge on the last byte ends the read
    task automatic recv_byte(input logic last);
        logic [7:0] r;
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            r[i] = s;
        end
        bit_io(last, s);
        o_rx_byte = r;
        o_rx_valid = 1'b1;
        @(negedge i_clk);
        o_rx_valid = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: bench/cgc_regs_test.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cgc_regs_test;
    localparam logic [6:0] ADDR = 7'h50;
    // identification values are arbitrary
    localparam logic [3:0] REV = 4'h3;
    localparam logic [3:0] MAKER = 4'hC;
    localparam logic [1:0] CLASS = 2'h1;
    localparam logic [5:0] CODE = 6'h15;
    logic I_SYS_CLK = 1'b0;
    logic I_RSTN = 1'b0;
    logic [1:0] I_SPREAD_STRAP = 2'h0;
    logic scl, host_sda, rx_valid, sda_w, sda_out, sda_oe, keep, ref_en, ack;
    logic [7:0] rx_byte;
    logic [1:0] spread, swing, edge_fast, ref_edge;
    logic [7:0] exp_q[$];
    logic [7:0] wd [8];
    logic [7:0] shadow [8];
    logic [31:0] r;
    logic [1:0] straps [3] = '{2'h0, 2'h1, 2'h3};
    int bad_count = 0;
    int n_tests = 0;
    int seed = 32'h5DD1;
    always #20 I_SYS_CLK = ~I_SYS_CLK;
    // open drain with pull-up: low if either side pulls
    assign sda_w = (sda_oe ? sda_out : 1'b1) & host_sda;
    cgc_regs #(.DEV_ADDR(ADDR), .REV_CODE(REV), .MAKER_CODE(MAKER),
        .PART_CLASS(CLASS), .PART_CODE(CODE)) u_cgc_regs (
        .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_SCL(scl),
        .I_SDA(sda_w), .I_SPREAD_STRAP(I_SPREAD_STRAP),
        .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_SPREAD_SEL(spread),
        .O_SWING_SEL(swing), .O_EDGE_FAST(edge_fast),
        .O_REF_EDGE(ref_edge), .O_REF_KEEP_PD(keep), .O_REF_EN(ref_en));
    cgc_host_model u_host (.i_clk(I_SYS_CLK), .i_sda(sda_w), .o_scl(scl),
        .o_sda(host_sda), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask
    task automatic do_reset(input logic [1:0] strap);
        I_RSTN = 1'b0;
        I_SPREAD_STRAP = strap;
        shadow = '{8'h00, {strap, 6'h06}, 8'hFF, 8'h5F, 8'hFF,
            {REV, MAKER}, {CLASS, CODE}, 8'h08};
        repeat (2) @(negedge I_SYS_CLK);
        I_RSTN = 1'b1;
        repeat (8) @(negedge I_SYS_CLK);
    endtask
    // shadow of what each written byte reads back as
    task automatic apply(input int idx, input logic [7:0] d);
        case (idx)
            1: shadow[1] = {I_SPREAD_STRAP, d[5:3], 1'b1, d[1:0]};
            2: shadow[2] = {5'h1F, d[2:1], 1'b1};
            3: shadow[3] = {d[7:4], 4'hF};
            7: shadow[7] = {3'h0, d[4:0]};
            default: ;
        endcase
    endtask
    task automatic chk_outs();
        logic [1:0] sel;
        sel = shadow[1][4:3];
        if (sel == 2'h2)
            sel = 2'h0;
        if (shadow[1][5] == 1'b0)
            sel = I_SPREAD_STRAP;
        check({6'h00, spread}, {6'h00, sel});
        check({6'h00, swing}, {6'h00, shadow[1][1:0]});
        check({6'h00, edge_fast}, {6'h00, shadow[2][2:1]});
        check({4'h0, ref_edge, keep, ref_en}, {4'h0, shadow[3][7:4]});
    endtask
    task automatic wr(input logic [6:0] a, input int idx, input int cnt,
        input int n);
        u_host.start();
        u_host.send_byte({a, 1'b0}, ack);
        check({7'h00, ack}, {7'h00, a != ADDR});
        if (a == ADDR)
        begin
            u_host.send_byte(idx[7:0], ack);
            u_host.send_byte(cnt[7:0], ack);
            check({7'h00, ack}, 8'h00);
            for (int i = 0; i < n; i++)
            begin
                u_host.send_byte(wd[i], ack);
                check({7'h00, ack}, {7'h00, i >= cnt});
                if (i < cnt)
                    apply(idx + i, wd[i]);
            end
        end
        u_host.stop();
    endtask
    task automatic rd(input int idx, input int n);
        exp_q.push_back(shadow[7]);
        for (int i = 0; i < n; i++)
            exp_q.push_back((idx + i < 8) ? shadow[(idx + i) % 8] : 8'h00);
        u_host.start();
        u_host.send_byte({ADDR, 1'b0}, ack);
        u_host.send_byte(idx[7:0], ack);
        u_host.start();
        u_host.send_byte({ADDR, 1'b1}, ack);
        check({7'h00, ack}, 8'h00);
        for (int i = 0; i <= n; i++)
            u_host.recv_byte(i == n);
        u_host.stop();
    endtask
    always @(posedge I_SYS_CLK)
    begin
        if (rx_valid === 1'b1)
        begin
            if (exp_q.size() > 0)
                check(rx_byte, exp_q.pop_front());
            else
                check(rx_byte, 8'hXX);
        end
    end
    initial
    begin
        repeat (60000) @(posedge I_SYS_CLK);
        bad_count++;
        stop_test();
    end
    initial
    begin
        foreach (straps[k])
        begin
            do_reset(straps[k]);
            chk_outs();
            rd(1, 1);
        end
        end_test("strap");
        rd(1, 8);
        end_test("read all");
        r = $random(seed);
        wd[0] = {r[7:6], 1'b0, 2'h3, r[2:0]};
        wr(ADDR, 1, 1, 1);
        chk_outs();
        for (int k = 0; k < 4; k++)
        begin
            r = $random(seed);
            wd[0] = {r[7:6], 1'b1, k[1:0], r[2:0]};
            wr(ADDR, 1, 1, 1);
            chk_outs();
        end
        rd(1, 1);
        end_test("override");
        r = $random(seed);
        wd[0] = r[7:0];
        wd[1] = r[15:8];
        wr(ADDR, 2, 2, 2);
        chk_outs();
        rd(2, 2);
        end_test("edge and reference");
        r = $random(seed);
        wd = '{r[7:0], r[15:8], r[23:16], r[31:24], 8'h00, 8'h00, 8'h00,
            8'h00};
        wr(ADDR, 1, 1, 2);
        wr(ADDR, 4, 4, 4);
        wr(7'h51, 1, 1, 1);
        rd(0, 8);
        chk_outs();
        end_test("fixed bytes and refusals");
        do_reset(2'h1);
        chk_outs();
        rd(1, 7);
        end_test("second reset");
        repeat (4) @(negedge I_SYS_CLK);
        stop_test();
    end
endmodule
`default_nettype wire
